// File: inc/sbsp_defines.vh
// constants for the synchronous burst sram port
`ifndef SBSP_DEFINES_VH
`define SBSP_DEFINES_VH
`define SBSP_ADDR_W 17
`define SBSP_LANES 4
`define SBSP_LANE_W 9
`define SBSP_BURST_W 2
`define SBSP_BURST_ZERO 2'h0
`define SBSP_BURST_ONE 2'h1
`define SBSP_ST_DESEL 2'h0
`define SBSP_ST_READ 2'h1
`define SBSP_ST_WRITE 2'h2
`define SBSP_ST_SLEEP 2'h3
`endif

// File: hw/sbsp_burst_ctr.v
// burst address counter with linear and interleaved order
`timescale 1ns/1ns
`include "sbsp_defines.vh"
module sbsp_burst_ctr #(
  parameter BW = `SBSP_BURST_W
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [BW-1:0] start_i,
  input wire step_i,
  input wire interleave_i,
  output wire [BW-1:0] low_addr_o,
  output wire [BW-1:0] low_next_o
);
  reg [BW-1:0] start_r;
  reg [BW-1:0] count_r;
  // --------------------------------------------------------------
  // start value and step count
  // --------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_r <= {BW{1'b0}};
      count_r <= {BW{1'b0}};
    end else if (load_i) begin
      start_r <= start_i;
      count_r <= {BW{1'b0}};
    end else if (step_i) begin
      count_r <= count_r + {{(BW-1){1'b0}}, 1'b1};
    end
  end
  // wraps inside four words by width alone
  assign low_addr_o = interleave_i ? (start_r ^ count_r) : (start_r + count_r);
  // value held after this edge, so a flow-through read of a freshly
  // loaded or stepped burst fetches the right word with no lag
  wire [BW-1:0] start_nxt = load_i ? start_i : start_r;
  wire [BW-1:0] count_nxt = load_i ? {BW{1'b0}} :
    (step_i ? count_r + {{(BW-1){1'b0}}, 1'b1} : count_r);
  assign low_next_o = interleave_i ? (start_nxt ^ count_nxt) : (start_nxt + count_nxt);
endmodule // sbsp_burst_ctr

// File: hw/sbsp_port.v
// synchronous flow-through burst sram port with storage array
//
// Behaviour
// - address captured with either strobe taken and all selects active
// - two low address bits seed the 2-bit burst counter
// - byte lane select writes its byte only with byte-write gate low
// - all-bytes write low writes every lane, ignoring lane selects and gate
// - burst-step low during a burst advances the counter by one
// - processor strobe ignored while first select is high
// - selects only evaluated on cycles where an address strobe is low
// - selected when first select low, second high, third low
// - data driven while output-drive low, input while high
// - first read clock after deselect keeps outputs disabled
// - accepted strobe loads full address and burst counter start
// - both strobes together: processor strobe alone acts unless first select is high
// - sleep input holds device idle with contents kept; unconnected means awake
// - build option with first select only
// - burst order strap: low linear, high interleaved, followed continuously via its synchroniser
// - outputs off during write data, after deselect and while deselected
// - parity bits behave as data, gated by their lane select
`timescale 1ns/1ns
`include "sbsp_defines.vh"
module sbsp_port #(
  parameter AW = `SBSP_ADDR_W,
  parameter LANES = `SBSP_LANES,
  parameter LW = `SBSP_LANE_W,
  parameter THREE_SELECTS = 1
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [AW-1:0] addr_i,
  input wire proc_addr_strobe_n_i,
  input wire ctrl_addr_strobe_n_i,
  input wire burst_step_n_i,
  input wire byte_write_gate_n_i,
  input wire [LANES-1:0] byte_lane_write_n_i,
  input wire all_bytes_write_n_i,
  input wire select_low_a_n_i,
  input wire select_high_b_i,
  input wire select_low_c_n_i,
  input wire output_drive_n_i,
  input wire sleep_request_i,
  input wire burst_order_i,
  input wire [LANES*LW-1:0] dq_in_i,
  output reg [LANES*LW-1:0] dq_out_o,
  output reg [LANES*LW-1:0] dq_oe_o,
  output reg sleeping_o
);
  localparam DW = LANES*LW;
  localparam DEPTH = 1 << AW;
  localparam BW = `SBSP_BURST_W;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // async pins pass two flops; sleep and output-drive gain two cycles of latency
  reg sleep_s1_r, sleep_s2_r, oe_s1_r, oe_s2_r, mode_s1_r, mode_s2_r;
  reg interleave_r;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
      oe_s1_r <= 1'b1;
      oe_s2_r <= 1'b1;
      mode_s1_r <= 1'b1;
      mode_s2_r <= 1'b1;
    end else begin
      sleep_s1_r <= sleep_request_i;
      sleep_s2_r <= sleep_s1_r;
      oe_s1_r <= output_drive_n_i;
      oe_s2_r <= oe_s1_r;
      mode_s1_r <= burst_order_i;
      mode_s2_r <= mode_s1_r;
    end
  end

  // strap follows the synchronised pin: a one-shot capture just after
  // release would latch the synchroniser's reset value, not the pin.
  // the pin is static in use, so following it costs nothing.
  // limitation: toggling it in mid-burst reorders the remaining words
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      interleave_r <= 1'b1; // pulled-up default is interleaved
    end else begin
      interleave_r <= mode_s2_r;
    end
  end

  // ------------------------------------------------------------
  // select and strobe decode
  // ------------------------------------------------------------
  function sel_ok;
    input a_n;
    input b;
    input c_n;
    begin
      if (THREE_SELECTS != 0)
        sel_ok = !a_n && b && !c_n;
      else
        sel_ok = !a_n;
    end
  endfunction

  wire selected = sel_ok(select_low_a_n_i, select_high_b_i, select_low_c_n_i);
  // processor strobe dropped when first select high; then controller may act
  wire proc_take = !proc_addr_strobe_n_i && !select_low_a_n_i;
  // controller strobe yields only to a processor strobe that is accepted,
  // so a refused processor strobe cannot also swallow a controller strobe
  wire ctrl_take = !ctrl_addr_strobe_n_i && !proc_take;
  wire strobe = (proc_take || ctrl_take) && !sleep_s2_r;
  wire load = strobe && selected;
  wire desel = strobe && !selected;

  // write qualification on the same edge
  reg [LANES-1:0] lane_we;
  always @* begin
    lane_we = {LANES{1'b0}};
    if (!all_bytes_write_n_i)
      lane_we = {LANES{1'b1}};
    else if (!byte_write_gate_n_i)
      lane_we = ~byte_lane_write_n_i;
  end
  wire any_we = |lane_we;

  // ------------------------------------------------------------
  // access state
  // ------------------------------------------------------------
  reg [1:0] state_r, state_nxt;
  reg [AW-1:0] addr_r;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `SBSP_ST_SLEEP: begin
        if (!sleep_s2_r)
          state_nxt = `SBSP_ST_DESEL;
      end
      default: begin
        if (sleep_s2_r)
          state_nxt = `SBSP_ST_SLEEP;
        else if (desel)
          state_nxt = `SBSP_ST_DESEL;
        else if (load || state_r != `SBSP_ST_DESEL)
          state_nxt = any_we ? `SBSP_ST_WRITE : `SBSP_ST_READ;
      end
    endcase
  end

  wire step = !burst_step_n_i && !load && state_r != `SBSP_ST_DESEL &&
    state_r != `SBSP_ST_SLEEP;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= `SBSP_ST_DESEL;
      addr_r <= {AW{1'b0}};
    end else begin
      state_r <= state_nxt;
      // selects only matter here; burst continuation keeps the old address
      if (load)
        addr_r <= addr_i;
    end
  end

  wire [BW-1:0] low_bits;
  wire [BW-1:0] low_next;
  sbsp_burst_ctr #(
    .BW(BW)
  ) u_ctr (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(load),
    .start_i(addr_i[BW-1:0]),
    .step_i(step),
    .interleave_i(interleave_r),
    .low_addr_o(low_bits),
    .low_next_o(low_next)
  );

  // ------------------------------------------------------------
  // storage array and data path
  // ------------------------------------------------------------
  reg [DW-1:0] mem [0:DEPTH-1];
  wire [AW-1:0] cur_addr = {addr_r[AW-1:BW], low_bits};
  wire active = state_r == `SBSP_ST_READ || state_r == `SBSP_ST_WRITE;
  // read address is the word this edge registers, taken from the counter's
  // next value so that interleaved and linear steps both land right
  wire [AW-1:0] rd_addr = load ? addr_i : {addr_r[AW-1:BW], low_next};
  // writes land on addr_i when a strobe loads, else on the word already registered for this data phase
  wire [AW-1:0] wr_addr = load ? addr_i : cur_addr;
  // first access out of deselect or sleep masks the drive for one clock
  wire first_nxt = load && (state_r == `SBSP_ST_DESEL || state_r == `SBSP_ST_SLEEP);

  // write lanes incl parity bit of each lane; a deselecting strobe cycle
  // must not write into the burst word that was left behind
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      always @(posedge core_clk_i) begin
        if ((load || (active && !desel && !sleep_s2_r)) && lane_we[g])
          mem[wr_addr][g*LW +: LW] <= dq_in_i[g*LW +: LW];
      end
    end
  endgenerate

  // registered read of the current burst word stands in for flow-through
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_out_o <= {DW{1'b0}};
      dq_oe_o <= {DW{1'b0}};
      sleeping_o <= 1'b0;
    end else begin
      sleeping_o <= state_nxt == `SBSP_ST_SLEEP;
      if (state_nxt == `SBSP_ST_READ)
        dq_out_o <= mem[rd_addr];
      dq_oe_o <= {DW{state_nxt == `SBSP_ST_READ && !oe_s2_r && !first_nxt}};
    end
  end
endmodule // sbsp_port

// File: tb/sbsp_host_model.sv
// host-side model driving the port's address, control and data inputs
`timescale 1ns/1ns
module sbsp_host_model (
  input wire core_clk_i,
  output reg [3:0] ad_o,
  output reg [4:0] c_o,
  output reg [3:0] ln_o,
  output reg [2:0] sel_o,
  output reg [35:0] dq_o,
  output reg drv_n_o,
  output reg zz_o,
  output reg ord_o
);
  // idle: strobes, step and write enables high, selects active, sleep low
  initial begin
    {ad_o, c_o, ln_o, sel_o, dq_o} = {4'h0, 5'h1F, 4'hF, 3'h2, 36'h0};
    {drv_n_o, zz_o, ord_o} = 3'h1;
  end
  // one cycle, c = {proc_n, ctrl_n, step_n, gate_n, all_n}; gate low with lanes
  task op(input [3:0] a, input [4:0] c, input [3:0] ln, input [35:0] d);
    begin
      ad_o = a;
      c_o = c;
      ln_o = ln;
      // released data flips so a stale word never looks valid
      dq_o = (c[0] && (c[1] || &ln)) ? ~dq_o : d;
      @(posedge core_clk_i);
      #1;
    end
  endtask
endmodule // sbsp_host_model

// File: tb/sbsp_port_checker.sv
// concurrent checks on the burst sram port outputs
`timescale 1ns/1ns
module sbsp_port_checker #(parameter LANES = 4, parameter LW = 9) (
  input wire core_clk_i,
  input wire rst_i,
  input wire proc_addr_strobe_n_i,
  input wire ctrl_addr_strobe_n_i,
  input wire byte_write_gate_n_i,
  input wire [LANES-1:0] byte_lane_write_n_i,
  input wire all_bytes_write_n_i,
  input wire select_low_a_n_i,
  input wire select_high_b_i,
  input wire select_low_c_n_i,
  input wire output_drive_n_i,
  input wire sleep_request_i,
  input wire [LANES*LW-1:0] dq_oe_o,
  input wire sleeping_o
);
  // decoded strobe, select and write qualifiers
  wire sel = !select_low_a_n_i && select_high_b_i && !select_low_c_n_i;
  wire load = !ctrl_addr_strobe_n_i || (!proc_addr_strobe_n_i && !select_low_a_n_i);
  wire wr = !all_bytes_write_n_i || (!byte_write_gate_n_i && !(&byte_lane_write_n_i));
  wire awake = !sleep_request_i && !sleeping_o;
  wire rd = !proc_addr_strobe_n_i && sel && !wr && !output_drive_n_i && awake;
  wire oe_off = dq_oe_o == {LANES*LW{1'b0}};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_oe_uniform: assert property (oe_off || &dq_oe_o) else $error("oe mixed");
  a_oe_off_hi: assert property (output_drive_n_i [*4] |-> oe_off) else $error("oe on");
  a_rd_drive_on: assert property (rd [*4] |=> &dq_oe_o) else $error("oe off");
  a_write_off: assert property (load && sel && wr && awake |=> oe_off)
    else $error("oe on in write");
  a_desel_off: assert property (load && !sel && awake |=> oe_off)
    else $error("oe on deselected");
  a_first_mask: assert property (load && !sel ##1 rd |=> oe_off)
    else $error("oe not masked");
  a_sleep_enter: assert property ($rose(sleep_request_i) |-> ##[1:4] sleeping_o)
    else $error("no sleep");
  a_sleep_leave: assert property (!sleep_request_i [*5] |-> !sleeping_o)
    else $error("still asleep");
endmodule // sbsp_port_checker
bind sbsp_port sbsp_port_checker #(.LANES(LANES), .LW(LW)) u_chk (.core_clk_i, .rst_i,
  .proc_addr_strobe_n_i, .ctrl_addr_strobe_n_i, .byte_write_gate_n_i, .byte_lane_write_n_i,
  .all_bytes_write_n_i, .select_low_a_n_i, .select_high_b_i, .select_low_c_n_i,
  .output_drive_n_i, .sleep_request_i, .dq_oe_o, .sleeping_o);

// File: tb/sbsp_port_tb.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ns
module sbsp_port_tb;
  reg core_clk_i = 1'b0;
  reg rst_i = 1'b1;
  wire [3:0] ad, ln;
  wire [4:0] c;
  wire [2:0] sel;
  wire [35:0] dq, q, oe;
  wire drv_n, zz, ord, slp;
  integer n_errors = 0, cmp_count = 0, cyc = 0, i;
  // rows: {addr, controls, lanes}, write data, word read back
  reg [12:0] rc [0:4] = '{{4'h1, 5'h0D, 4'h0}, {4'h1, 5'h0D, 4'hE}, {4'h1, 5'h0F, 4'h0},
    {4'h1, 5'h0E, 4'hF}, {4'h2, 5'h16, 4'hF}};
  reg [35:0] rd [0:4] = '{36'h123456789, 36'hFEDCBA987, 36'h111111111, 36'h0F0F0F0F0,
    36'hA5A5A5A5A};
  reg [35:0] rx [0:4] = '{36'h123456789, 36'h123456787, 36'h123456787, 36'h0F0F0F0F0,
    36'hA5A5A5A5A};
  sbsp_host_model host (.core_clk_i(core_clk_i), .ad_o(ad), .c_o(c), .ln_o(ln), .sel_o(sel),
    .dq_o(dq), .drv_n_o(drv_n), .zz_o(zz), .ord_o(ord));
  sbsp_port #(.AW(4)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(ad),
    .proc_addr_strobe_n_i(c[4]), .ctrl_addr_strobe_n_i(c[3]), .burst_step_n_i(c[2]),
    .byte_write_gate_n_i(c[1]), .byte_lane_write_n_i(ln), .all_bytes_write_n_i(c[0]),
    .select_low_a_n_i(sel[2]), .select_high_b_i(sel[1]), .select_low_c_n_i(sel[0]),
    .output_drive_n_i(drv_n), .sleep_request_i(zz), .burst_order_i(ord), .dq_in_i(dq),
    .dq_out_o(q), .dq_oe_o(oe), .sleeping_o(slp));
  always #5 core_clk_i = ~core_clk_i;
  // hang guard, far above the roughly 60 cycles the run needs
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [35:0] e, input [35:0] s);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("BAD %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // read with both strobes low, data flows through right after the edge
  task rdc(input [3:0] a, input [35:0] e);
    begin
      host.op(a, 5'h07, 4'hF, 36'h0);
      chk("dq_out", e, q);
    end
  endtask
  // strap is followed continuously via its synchroniser; each order still gets a fresh reset
  task burst(input o);
    begin
      host.ord_o = o;
      rst_i = 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      for (i = 4; i < 8; i = i + 1) host.op(i[3:0], 5'h0E, 4'hF, 36'(i));
      rdc(4'h5, 36'h5);
      host.sel_o = 3'h5;
      for (i = 1; i < 4; i = i + 1) begin
        host.op(4'h0, 5'h1B, 4'hF, 36'h0);
        chk("burst", 36'(4 + (o ? (1 ^ i) : ((1 + i) % 4))), q);
      end
      host.sel_o = 3'h2;
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    burst(1'b1);
    burst(1'b0);
    for (i = 0; i < 5; i = i + 1) begin
      host.op(rc[i][12:9], rc[i][8:4], rc[i][3:0], rd[i]);
      rdc(rc[i][12:9], rx[i]);
    end
    host.op(4'h3, 5'h0E, 4'hF, 36'h333);
    host.sel_o = 3'h6;
    host.op(4'h8, 5'h0E, 4'hF, 36'h777);
    host.sel_o = 3'h0;
    host.op(4'h3, 5'h0E, 4'hF, 36'h999);
    host.sel_o = 3'h2;
    rdc(4'h3, 36'h777);
    chk("dq_oe", 36'h0, oe);
    repeat (3) rdc(4'h3, 36'h777);
    chk("dq_oe", {36{1'b1}}, oe);
    host.drv_n_o = 1'b1;
    repeat (5) host.op(4'h3, 5'h1F, 4'hF, 36'h0);
    chk("dq_oe", 36'h0, oe);
    host.drv_n_o = 1'b0;
    host.zz_o = 1'b1;
    repeat (5) host.op(4'h3, 5'h1F, 4'hF, 36'h0);
    chk("sleeping", 36'h1, {35'h0, slp});
    host.op(4'h3, 5'h0E, 4'hF, 36'h555);
    host.zz_o = 1'b0;
    repeat (5) host.op(4'h3, 5'h1F, 4'hF, 36'h0);
    chk("sleeping", 36'h0, {35'h0, slp});
    rdc(4'h3, 36'h777);
    print_verdict;
  end
endmodule // sbsp_port_tb
